// ===== hw/pcm_pkg.sv
// Shared constants, types and helpers for the pixel colour-matrix stage.
// Functional notes
// - Multiply each RGBA group, as a column vector, by the 4x4 colour matrix.
// - Multiply each matrix output by its own signed per-channel scale.
// - Add a signed per-channel bias after scaling.
// - Scaled, biased matrix outputs replace all four original components.
// - One post-matrix lookup enable bit, cleared by reset, lookup bypassed.
// - Enabled lookup acts as colour table lookup with its own table.
// - Histogram enable; when off, groups pass without touching counts.
// - Non-zero width: index is clamp to [0,1], times width-1, rounded.
// - Index derivation leaves the group's components unchanged.
// - Each channel present in histogram format adds one at its index.
// - Count overflow may wrap freely and raises no error.
// - Histogram sink clear: every group is forwarded unchanged.
// - Histogram sink set: drop groups after update, skip minmax for them.
// - Dropped groups give no output; configuration state still updates.
// - Minmax enable control, acting only on RGBA groups.
// - Red minimum replaced only when red value is strictly smaller.
// - Red maximum replaced only when red value is strictly larger.
// - Green, blue, alpha use same rule, only when in minmax format.
// - Minimum and maximum kept at least as wide as colour range.
// - Minmax sink clear passes stream; set drops groups after update.
// - Out-of-range values in minmax compare need no special handling.
package pcm_pkg;
  localparam int          PW   = 16;
  localparam int          FRAC = 12;
  localparam logic [15:0] ONE  = 16'h1000;
  localparam logic [31:0] HALF = 32'h0000_0800;
  typedef logic [3:0][PW-1:0] pcm_pix_t;
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_FMT   = 12'h001;
  localparam logic [11:0] A_HWID  = 12'h002;
  localparam logic [11:0] A_MMCLR = 12'h003;
  localparam logic [11:0] A_MAT   = 12'h010;
  localparam logic [11:0] A_SB    = 12'h020;
  localparam logic [11:0] A_MM    = 12'h028;
  localparam logic [1:0]  A_LUT   = 2'h1;
  localparam logic [1:0]  A_HIST  = 2'h2;
  localparam int B_LUT  = 0;
  localparam int B_HEN  = 1;
  localparam int B_HSNK = 2;
  localparam int B_MEN  = 3;
  localparam int B_MSNK = 4;
  localparam int F_HFMT = 0;
  localparam int F_MFMT = 4;
  localparam int F_LFMT = 8;
  localparam logic [4:0]  CTRL_RST = 5'h00;
  localparam logic [11:0] FMT_RST  = 12'hfff;
  localparam logic [15:0] HWID_RST = 16'h0000;
  localparam logic [15:0] MN_RST   = 16'h7fff;
  localparam logic [15:0] MX_RST   = 16'h8000;

  // Clamps to [0,1], scales by n and rounds to nearest.
  function automatic logic [15:0] pcm_index(input logic [15:0] c, input logic [15:0] n);
    logic [15:0] k;
    logic [31:0] p;
    k = c[15] ? 16'h0000 : ((c > ONE) ? ONE : c);
    p = {16'h0000, k} * {16'h0000, n} + HALF;
    return p[FRAC+15:FRAC];
  endfunction

  function automatic logic [15:0] pcm_sat(input logic signed [49:0] t);
    if (t > 50'sd32767)
      return 16'h7fff;
    else if (t < -50'sd32768)
      return 16'h8000;
    return t[15:0];
  endfunction
endpackage

// ===== hw/pcm_tab_if.sv
// Software access port to one of the internal tables.
`timescale 1ns/1ps
interface pcm_tab_if #(parameter int AW = 8);
  logic          we;
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic [15:0]   rdata;
  modport host (output we, output addr, output wdata, input rdata);
  modport tab  (input we, input addr, input wdata, output rdata);
endinterface

// ===== hw/pcm_lut.sv
// Post-matrix colour table: per-channel lookup with software write port.
`timescale 1ns/1ps
module pcm_lut #(
  parameter int DEPTH = 64
) (
  input  wire logic              clk,
  input  wire pcm_pkg::pcm_pix_t pix,
  input  wire logic [3:0]        fmt,
  output pcm_pkg::pcm_pix_t      res,
  pcm_tab_if.tab                 sw
);
  import pcm_pkg::*;
  localparam int IW = $clog2(DEPTH);
  localparam logic [15:0] LAST = 16'(DEPTH - 1);

  logic [15:0] tab [4][DEPTH];
  logic [15:0] next_tab [4][DEPTH];

  always_comb begin
    next_tab = tab;
    if (sw.we)
      next_tab[sw.addr[IW+1:IW]][sw.addr[IW-1:0]] = sw.wdata;
  end

  always_ff @(posedge clk) begin
    tab <= next_tab;
  end

  assign sw.rdata = tab[sw.addr[IW+1:IW]][sw.addr[IW-1:0]];

  // Channels absent from the table format keep their value.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_ch
      logic [15:0] ix;
      assign ix     = pcm_index(pix[i], LAST);
      assign res[i] = fmt[i] ? tab[i][ix[IW-1:0]] : pix[i];
    end
  endgenerate
endmodule

// ===== hw/pcm_hist.sv
// Histogram counters: per-channel count tables with software access.
`timescale 1ns/1ps
module pcm_hist #(
  parameter int DEPTH = 64,
  parameter int CW    = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              upd,
  input  wire pcm_pkg::pcm_pix_t pix,
  input  wire logic [15:0]       width,
  input  wire logic [3:0]        fmt,
  pcm_tab_if.tab                 sw
);
  import pcm_pkg::*;
  localparam int IW = $clog2(DEPTH);

  logic [CW-1:0] cnt [4][DEPTH];
  logic [CW-1:0] next_cnt [4][DEPTH];
  logic [IW-1:0] idx [4];
  logic          go;

  assign go = upd && (width != 16'h0000);

  generate
    for (genvar i = 0; i < 4; i++) begin : g_ix
      logic [15:0] full;
      assign full   = pcm_index(pix[i], width - 16'h0001);
      assign idx[i] = full[IW-1:0];
    end
  endgenerate

  // A software write and an increment on the same entry both take effect.
  always_comb begin
    next_cnt = cnt;
    if (sw.we)
      next_cnt[sw.addr[IW+1:IW]][sw.addr[IW-1:0]] = CW'(sw.wdata);
    for (int i = 0; i < 4; i++) begin
      if (go && fmt[i])
        next_cnt[i][idx[i]] = next_cnt[i][idx[i]] + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++)
        for (int j = 0; j < DEPTH; j++)
          cnt[i][j] <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign sw.rdata = 16'(cnt[sw.addr[IW+1:IW]][sw.addr[IW-1:0]]);

  chk_hist_inc : assert property (@(posedge clk) disable iff (rst)
    go && fmt[0] && !sw.we |=> cnt[0][$past(idx[0])] == CW'($past(cnt[0][idx[0]]) + 1'b1))
    else $error("red histogram count did not advance by one");

  chk_hist_idle : assert property (@(posedge clk) disable iff (rst)
    !upd && !sw.we |=> cnt[1][$past(idx[1])] == $past(cnt[1][idx[1]]))
    else $error("green histogram count moved without an update");
endmodule

// ===== hw/pcm_top.sv
// Pixel stage: colour matrix, post-matrix lookup, histogram and minmax.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pcm_top #(
  parameter int DEPTH = 64,
  parameter int CW    = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic              in_rgba,
  input  wire pcm_pkg::pcm_pix_t in_pix,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic                   out_rgba,
  output pcm_pkg::pcm_pix_t      out_pix,
  input  wire logic [11:0]       reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic [31:0]            reg_rdata
);
  import pcm_pkg::*;
  localparam int IW = $clog2(DEPTH);

  logic [4:0]         ctrl, next_ctrl;
  logic [11:0]        fmt, next_fmt;
  logic [15:0]        hwid, next_hwid;
  logic signed [15:0] mat [16];
  logic signed [15:0] next_mat [16];
  logic signed [15:0] scl [4];
  logic signed [15:0] next_scl [4];
  logic signed [15:0] bia [4];
  logic signed [15:0] next_bia [4];
  logic signed [15:0] mn [4];
  logic signed [15:0] next_mn [4];
  logic signed [15:0] mx [4];
  logic signed [15:0] next_mx [4];

  logic      v1, next_v1, r1, next_r1;
  logic      v2, next_v2, r2, next_r2;
  pcm_pix_t  d1, next_d1, d2, next_d2;
  pcm_pix_t  mres, lres;
  logic      next_out_valid, next_out_rgba;
  pcm_pix_t  next_out_pix;
  logic [31:0] next_rdata;

  logic adv, lut_en, hist_en, mm_en, hdrop, mdrop, hupd, mupd, mclr;

  pcm_tab_if #(.AW(IW + 2)) lut_sw ();
  pcm_tab_if #(.AW(IW + 2)) hist_sw ();

  assign adv      = !out_valid || out_ready;
  assign in_ready = adv;
  assign lut_en   = ctrl[B_LUT];
  assign hist_en  = ctrl[B_HEN];
  assign mm_en    = ctrl[B_MEN];
  // A histogram sink stops the group before the minmax stage.
  assign hdrop    = hist_en && ctrl[B_HSNK];
  assign mdrop    = mm_en && ctrl[B_MSNK];
  assign hupd     = adv && v2 && r2 && hist_en;
  assign mupd     = adv && v2 && r2 && mm_en && !hdrop;
  assign mclr     = reg_we && (reg_addr == A_MMCLR);

  assign lut_sw.we    = reg_we && (reg_addr[11:10] == A_LUT);
  assign lut_sw.addr  = reg_addr[IW+1:0];
  assign lut_sw.wdata = reg_wdata[15:0];
  assign hist_sw.we    = reg_we && (reg_addr[11:10] == A_HIST);
  assign hist_sw.addr  = reg_addr[IW+1:0];
  assign hist_sw.wdata = reg_wdata[15:0];

  pcm_lut #(.DEPTH(DEPTH)) u_lut (
    .clk (clk),
    .pix (d1),
    .fmt (fmt[F_LFMT +: 4]),
    .res (lres),
    .sw  (lut_sw)
  );

  pcm_hist #(.DEPTH(DEPTH), .CW(CW)) u_hist (
    .clk   (clk),
    .rst   (rst),
    .upd   (hupd),
    .pix   (d2),
    .width (hwid),
    .fmt   (fmt[F_HFMT +: 4]),
    .sw    (hist_sw)
  );

  // Configuration registers written by software.
  always_comb begin
    next_ctrl = ctrl;
    next_fmt  = fmt;
    next_hwid = hwid;
    next_mat  = mat;
    next_scl  = scl;
    next_bia  = bia;
    if (reg_we) begin
      if (reg_addr == A_CTRL)
        next_ctrl = reg_wdata[4:0];
      else if (reg_addr == A_FMT)
        next_fmt = reg_wdata[11:0];
      else if (reg_addr == A_HWID)
        next_hwid = reg_wdata[15:0];
      else if (reg_addr[11:4] == A_MAT[11:4])
        next_mat[reg_addr[3:0]] = reg_wdata[15:0];
      else if (reg_addr[11:3] == A_SB[11:3]) begin
        if (reg_addr[2])
          next_bia[reg_addr[1:0]] = reg_wdata[15:0];
        else
          next_scl[reg_addr[1:0]] = reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      fmt  <= FMT_RST;
      hwid <= HWID_RST;
      for (int i = 0; i < 16; i++)
        mat[i] <= (i % 5 == 0) ? ONE : 16'h0000;
      for (int i = 0; i < 4; i++) begin
        scl[i] <= ONE;
        bia[i] <= 16'h0000;
      end
    end else begin
      ctrl <= next_ctrl;
      fmt  <= next_fmt;
      hwid <= next_hwid;
      mat  <= next_mat;
      scl  <= next_scl;
      bia  <= next_bia;
    end
  end

  // Matrix product, then scale and bias, saturated to the pixel width.
  always_comb begin
    logic signed [33:0] acc;
    logic signed [49:0] t;
    acc  = '0;
    t    = '0;
    mres = '0;
    for (int i = 0; i < 4; i++) begin
      acc = '0;
      for (int j = 0; j < 4; j++)
        acc = acc + 34'(mat[4*i+j] * $signed(in_pix[j]));
      t = 50'(acc >>> FRAC) * scl[i];
      t = (t >>> FRAC) + bia[i];
      mres[i] = pcm_sat(t);
    end
  end

  // Three-stage pipeline; every stage holds while the output is stalled.
  always_comb begin
    next_v1        = v1;
    next_r1        = r1;
    next_d1        = d1;
    next_v2        = v2;
    next_r2        = r2;
    next_d2        = d2;
    next_out_valid = out_valid;
    next_out_rgba  = out_rgba;
    next_out_pix   = out_pix;
    if (adv) begin
      next_v1 = in_valid;
      if (in_valid) begin
        next_r1 = in_rgba;
        next_d1 = in_rgba ? mres : in_pix;
      end
      next_v2 = v1;
      if (v1) begin
        next_r2 = r1;
        next_d2 = (r1 && lut_en) ? lres : d1;
      end
      // Dropped groups never reach the output port.
      next_out_valid = v2 && !(r2 && (hdrop || mdrop));
      if (v2) begin
        next_out_rgba = r2;
        next_out_pix  = d2;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      v1        <= 1'b0;
      r1        <= 1'b0;
      d1        <= '0;
      v2        <= 1'b0;
      r2        <= 1'b0;
      d2        <= '0;
      out_valid <= 1'b0;
      out_rgba  <= 1'b0;
      out_pix   <= '0;
    end else begin
      v1        <= next_v1;
      r1        <= next_r1;
      d1        <= next_d1;
      v2        <= next_v2;
      r2        <= next_r2;
      d2        <= next_d2;
      out_valid <= next_out_valid;
      out_rgba  <= next_out_rgba;
      out_pix   <= next_out_pix;
    end
  end

  // Minmax table; a restart write is applied first so a same-cycle group still counts.
  always_comb begin
    next_mn = mn;
    next_mx = mx;
    if (mclr) begin
      for (int i = 0; i < 4; i++) begin
        next_mn[i] = MN_RST;
        next_mx[i] = MX_RST;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (mupd && fmt[F_MFMT + i]) begin
        if ($signed(d2[i]) < next_mn[i])
          next_mn[i] = d2[i];
        if ($signed(d2[i]) > next_mx[i])
          next_mx[i] = d2[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        mn[i] <= MN_RST;
        mx[i] <= MX_RST;
      end
    end else begin
      mn <= next_mn;
      mx <= next_mx;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_re) begin
      if (reg_addr == A_CTRL)
        next_rdata = {27'h0000000, ctrl};
      else if (reg_addr == A_FMT)
        next_rdata = {20'h00000, fmt};
      else if (reg_addr == A_HWID)
        next_rdata = {16'h0000, hwid};
      else if (reg_addr[11:4] == A_MAT[11:4])
        next_rdata = {16'h0000, mat[reg_addr[3:0]]};
      else if (reg_addr[11:3] == A_SB[11:3])
        next_rdata = {16'h0000, reg_addr[2] ? bia[reg_addr[1:0]] : scl[reg_addr[1:0]]};
      else if (reg_addr[11:3] == A_MM[11:3])
        next_rdata = {16'h0000, reg_addr[2] ? mx[reg_addr[1:0]] : mn[reg_addr[1:0]]};
      else if (reg_addr[11:10] == A_LUT)
        next_rdata = {16'h0000, lut_sw.rdata};
      else if (reg_addr[11:10] == A_HIST)
        next_rdata = {16'h0000, hist_sw.rdata};
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= next_rdata;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reset_state : assert property (
    $fell(rst) |-> ctrl == CTRL_RST && scl[1] == ONE && mat[5] == ONE && mat[1] == 0 && bia[2] == 0)
    else $error("reset did not restore identity configuration");

  chk_bypass_nonrgba : assert property (
    adv && in_valid && !in_rgba |=> v1 && !r1 && d1 == $past(in_pix))
    else $error("non-RGBA group was altered by the matrix stage");

  chk_lut_bypass : assert property (
    adv && v1 && !lut_en |=> d2 == $past(d1))
    else $error("lookup applied while disabled");

  chk_pass_nosink : assert property (
    adv && v2 && !hdrop && !mdrop |=> out_valid && out_pix == $past(d2))
    else $error("group not forwarded with sinks clear");

  chk_hist_drop : assert property (
    adv && v2 && r2 && hdrop && !reg_we |=> !out_valid && mn[0] == $past(mn[0]) && mx[3] == $past(mx[3]))
    else $error("histogram sink group reached output or minmax");

  chk_mm_drop : assert property (
    adv && v2 && r2 && mdrop |=> !out_valid)
    else $error("minmax sink group reached output");

  chk_min_strict : assert property (
    !reg_we |=> mn[0] <= $past(mn[0]) && (mn[0] == $past(mn[0]) || mn[0] == $past(d2[0])))
    else $error("red minimum moved the wrong way");

  chk_max_strict : assert property (
    !reg_we |=> mx[0] >= $past(mx[0]) && (mx[0] == $past(mx[0]) || mx[0] == $past(d2[0])))
    else $error("red maximum moved the wrong way");

  chk_mm_format : assert property (
    !reg_we && !fmt[F_MFMT + 1] |=> mn[1] == $past(mn[1]) && mx[1] == $past(mx[1]))
    else $error("green minmax changed while absent from format");

  // A stalled output must not move, and groups of other kinds pass every stage untouched.
  chk_stall_hold : assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_pix) && $stable(out_rgba))
    else $error("output group changed while stalled");

  chk_nonrgba_keep : assert property (
    adv && v2 && !r2 |=> out_valid && !out_rgba && out_pix == $past(d2))
    else $error("non-RGBA group was dropped or altered at the output");

  chk_nonrgba_lut : assert property (
    adv && v1 && !r1 |=> !r2 && d2 == $past(d1))
    else $error("non-RGBA group was altered by the lookup stage");

  chk_nonrgba_mm : assert property (
    adv && v2 && !r2 && !reg_we |=> mn[0] == $past(mn[0]) && mx[0] == $past(mx[0]))
    else $error("non-RGBA group updated the minmax table");

  chk_mm_disabled : assert property (
    !mm_en && !reg_we |=> mn[2] == $past(mn[2]) && mx[2] == $past(mx[2]))
    else $error("minmax table changed while the stage was disabled");

  chk_sink_gated : assert property (
    adv && v2 && r2 && !hist_en && !mdrop |=> out_valid)
    else $error("group dropped by a histogram sink that was not enabled");

  chk_mm_restart : assert property (
    mclr && !mupd |=> mn[3] == MN_RST && mx[3] == MX_RST)
    else $error("minmax restart did not reload the limits");

  chk_sink_reset : assert property (
    $fell(rst) |-> !hist_en && !mm_en && !ctrl[B_HSNK] && !ctrl[B_MSNK] && scl[3] == ONE)
    else $error("reset did not clear enables and sinks");

  chk_out_reset : assert property (
    $fell(rst) |-> !out_valid && !out_rgba && out_pix == '0 && reg_rdata == 32'h0 && bia[3] == 0)
    else $error("reset did not clear the output side");
endmodule

// ===== tb/pcm_src.sv
// Upstream pixel source model that feeds queued groups into the stage.
`timescale 1ns/1ps
module pcm_src (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         slow,
  input  wire logic         in_ready,
  output logic              in_valid,
  output logic              in_rgba,
  output pcm_pkg::pcm_pix_t in_pix
);
  import pcm_pkg::*;
  logic [64:0] q[$];
  logic [64:0] g;
  initial begin
    in_valid = 1'b0;
    in_rgba  = 1'b0;
    in_pix   = '0;
  end
  // A group is held until taken; idle lines toggle so stale data never looks valid.
  always @(posedge clk) begin
    if (rst) begin
      in_valid <= 1'b0;
    end else if (!in_valid || in_ready) begin
      if (q.size() > 0 && !(slow && in_valid)) begin
        g = q.pop_front();
        in_valid <= 1'b1;
        in_rgba  <= g[64];
        in_pix   <= g[63:0];
      end else begin
        in_valid <= 1'b0;
        in_rgba  <= ~in_rgba;
        in_pix   <= ~in_pix;
      end
    end
  end
endmodule

// ===== tb/pcm_top_tb.sv
// Self-checking testbench for the colour matrix, lookup, histogram and minmax stage.
`timescale 1ns/1ps
module pcm_top_tb;
  import pcm_pkg::*;
  logic        clk, rst, slow, out_ready, reg_we, reg_re;
  logic        in_valid, in_ready, in_rgba, out_valid, out_rgba;
  pcm_pix_t    in_pix, out_pix;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [64:0] exp_q[$];
  int          error_cnt, checks_done;

  pcm_src i_src (.clk(clk), .rst(rst), .slow(slow), .in_ready(in_ready),
    .in_valid(in_valid), .in_rgba(in_rgba), .in_pix(in_pix));
  pcm_top i_dut (.clk(clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
    .in_rgba(in_rgba), .in_pix(in_pix), .out_valid(out_valid), .out_ready(out_ready),
    .out_rgba(out_rgba), .out_pix(out_pix), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= {16'h0000, d};
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re   <= 1'b0;
    #1;
    chk(65'(reg_rdata), 65'(e));
  endtask

  task automatic send(input logic r, input logic [63:0] p, input logic [63:0] e,
                      input logic keep);
    i_src.q.push_back({r, p});
    if (keep)
      exp_q.push_back({r, e});
  endtask

  // Waits for all queued groups to leave, plus margin for any group that should be dropped.
  task automatic drain();
    int n;
    n = 0;
    while ((i_src.q.size() > 0 || exp_q.size() > 0 || in_valid) && n < 100) begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    if (n >= 100) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
    end
  endtask

  always @(posedge clk) begin
    if (!rst && out_valid && out_ready) begin
      if (exp_q.size() > 0)
        chk({out_rgba, out_pix}, exp_q.pop_front());
      else
        chk(65'(exp_q.size()), 65'h1);
    end
  end

  task automatic t_reset();
    rdc(A_CTRL, 32'h0);
    rdc(A_FMT, 32'h0fff);
    rdc(A_HWID, 32'h0);
    rdc(A_SB, 32'h1000);
    rdc(A_SB + 12'h4, 32'h0);
    rdc(A_MAT + 12'h5, 32'h1000);
    rdc(A_MAT + 12'h1, 32'h0);
    rdc(A_MM, 32'h7fff);
    rdc(A_MM + 12'h4, 32'h8000);
    rdc(12'h3f0, 32'h0);
  endtask

  task automatic t_matrix();
    logic [63:0] p;
    p = {16'h0400, 16'h0300, 16'h0200, 16'h0100};
    @(posedge clk);
    out_ready <= 1'b0;
    send(1'b1, p, p, 1'b1);
    send(1'b1, ~p, ~p, 1'b1);
    send(1'b1, p, p, 1'b1);
    repeat (8) @(posedge clk);
    #1;
    chk(65'({out_valid, in_ready}), 65'h2);
    @(posedge clk);
    out_ready <= 1'b1;
    drain();
    wr(A_MAT + 12'h1, 16'h1000);
    wr(A_SB, 16'h2000);
    wr(A_SB + 12'h4, 16'h0100);
    wr(A_SB + 12'h7, 16'hff00);
    send(1'b1, p, {16'h0300, 16'h0300, 16'h0200, 16'h0700}, 1'b1);
    send(1'b0, p, p, 1'b1);
    drain();
    wr(A_MAT + 12'h1, 16'h0000);
    wr(A_SB, 16'h1000);
    wr(A_SB + 12'h4, 16'h0000);
    wr(A_SB + 12'h7, 16'h0000);
  endtask

  task automatic t_lut();
    wr(12'h43f, 16'h0abc);
    wr(A_FMT, 16'h01ff);
    wr(A_CTRL, 16'h0001);
    slow <= 1'b1;
    send(1'b1, 64'h0400_0300_0123_1000, 64'h0400_0300_0123_0abc, 1'b1);
    send(1'b1, 64'h0001_0002_0003_1000, 64'h0001_0002_0003_0abc, 1'b1);
    drain();
    slow <= 1'b0;
    wr(A_CTRL, 16'h0000);
    wr(A_FMT, 16'h0fff);
  endtask

  task automatic t_hist();
    logic [63:0] p;
    p = {16'h2000, 16'hf000, 16'h0800, 16'h1000};
    wr(A_HWID, 16'h0004);
    wr(A_CTRL, 16'h0002);
    send(1'b1, p, p, 1'b1);
    drain();
    rdc(12'h803, 32'h1);
    rdc(12'h842, 32'h1);
    rdc(12'h880, 32'h1);
    rdc(12'h8c3, 32'h1);
    rdc(12'h841, 32'h0);
    wr(A_CTRL, 16'h0000);
    send(1'b1, p, p, 1'b1);
    drain();
    rdc(12'h803, 32'h1);
    wr(A_CTRL, 16'h000e);
    wr(A_FMT, 16'h0ffd);
    send(1'b1, p, p, 1'b0);
    send(1'b0, p, p, 1'b1);
    drain();
    rdc(12'h803, 32'h2);
    rdc(12'h842, 32'h1);
    rdc(A_MM, 32'h7fff);
    wr(A_CTRL, 16'h0000);
  endtask

  task automatic t_minmax();
    wr(A_FMT, 16'h0f1f);
    wr(A_MMCLR, 16'h0000);
    wr(A_CTRL, 16'h0008);
    send(1'b1, 64'h0000_0000_0100_0300, 64'h0000_0000_0100_0300, 1'b1);
    send(1'b1, 64'h0000_0000_0500_0100, 64'h0000_0000_0500_0100, 1'b1);
    drain();
    rdc(A_MM, 32'h0100);
    rdc(A_MM + 12'h4, 32'h0300);
    rdc(A_MM + 12'h1, 32'h7fff);
    wr(A_FMT, 16'h0f3f);
    send(1'b1, 64'h0000_0000_0200_0200, 64'h0000_0000_0200_0200, 1'b1);
    drain();
    rdc(A_MM, 32'h0100);
    rdc(A_MM + 12'h4, 32'h0300);
    rdc(A_MM + 12'h5, 32'h0200);
    wr(A_CTRL, 16'h0018);
    send(1'b1, 64'h0000_0000_0000_ff00, 64'h0, 1'b0);
    drain();
    rdc(A_MM, 32'hff00);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  initial begin
    rst       = 1'b1;
    slow      = 1'b0;
    out_ready = 1'b1;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_matrix();
    t_lut();
    t_hist();
    t_minmax();
    test_done();
  end
endmodule
